// ===== fmp_map.svh
`ifndef FMP_MAP_SVH
`define FMP_MAP_SVH
`define SET_INPUT_CHANNELS_LESS_ONE 10'h104
`define SET_INPUT_NUMBER_FORMAT     10'h105
`define SET_INPUT_UPSAMPLING        10'h107
`define SET_INPUT_OFFSET_VALUE      10'h109
`define SET_INPUT_TILE_A_WIDTH      10'h10A
`define SET_INPUT_TILE_A_HEIGHT     10'h10B
`define SET_INPUT_TILE_B_HEIGHT     10'h10C
`define SET_INPUT_BUFFER_LIMIT      10'h10D
`define SET_INPUT_BASE_SELECT       10'h10F
`define SET_OUTPUT_STRIPE_WIDTH     10'h111
`define SET_OUTPUT_STRIPE_HEIGHT    10'h112
`define SET_OUTPUT_STRIPE_DEPTH     10'h113
`define SET_OUTPUT_NUMBER_FORMAT    10'h114
`define SET_OUTPUT_BLOCK_WIDTH      10'h115
`define SET_OUTPUT_BLOCK_HEIGHT     10'h116
`define SET_OUTPUT_BLOCK_DEPTH      10'h117
`define SET_OUTPUT_OFFSET_VALUE     10'h118
`define SET_OUTPUT_TILE_A_WIDTH     10'h11A
`define SET_OUTPUT_TILE_A_HEIGHT    10'h11B
`define SET_OUTPUT_TILE_B_HEIGHT    10'h11C
`define SET_OUTPUT_BASE_SELECT      10'h11F
`define SET_FILTER_SPAN_X           10'h120
`define SET_FILTER_SPAN_Y           10'h121
`define SET_ACTIVATION              10'h125
`define OP_GROUP_BASE  10'h100
`define NO_SLOT        5'h1F
`define PARAM_RESET    16'h0000
`define FMT_SIGN_BIT   0
`define IN_PREC_LSB    2
`define OUT_PREC_LSB   1
`define FMT_LAYOUT_LSB 6
`define FMT_SCALE_LSB  8
`define FMT_ROUND_LSB  14
`define UPSCALE_LSB    0
`define CLIP_LSB       12
`define IB_END_MAX     16'h0030
`define BLK_WH_MAX     16'h001F
`define BLK_D_MIN      16'h0003
`define BLK_D_MAX      16'h007F
`define REG_CTRL       12'h000
`define REG_STATUS     12'h004
`define REG_INJECT     12'h008
`define REG_REGION     12'h040
`define REG_PARAM      12'h400
`define CTRL_RESET     1'b1
`define CTRL_EN_BIT    0
`define CTRL_CLR_BIT   1
`define STAT_RSV_BIT   0
`define STAT_RNG_BIT   1
`define CMD_OP_LSB     16
`endif

// ===== fmp_pkg.sv
`default_nettype none
package fmp_pkg;
	typedef logic [15:0] param_t;
	typedef logic [16:0] zero_point_t;
	typedef logic [9:0]  opcode_t;
	typedef logic [4:0]  slot_t;
	typedef logic [5:0]  buf_limit_t;
	typedef logic [4:0]  blk_wh_t;
	typedef logic [6:0]  blk_d_t;
	typedef logic [3:0]  clip_t;
	typedef enum logic [1:0] {PREC_8BIT, PREC_16BIT, PREC_32BIT} precision_t;
	typedef enum logic [1:0] {PIXEL_MAJOR_LAYOUT, CHANNEL_BRICK_LAYOUT} layout_t;
	typedef enum logic [1:0] {SCALE_16_BOTH, SCALE_32_FIRST, SCALE_32_SECOND} in_scale_t;
	typedef enum logic [1:0] {UPSCALE_NONE, UPSCALE_NEAREST, UPSCALE_ZEROS} upscale_t;
	typedef enum logic [1:0] {ROUND_DOUBLE, ROUND_TRUNCATE, ROUND_NATURAL} out_round_t;
endpackage
`default_nettype wire

// ===== feature_map_param_decoder.sv
// The placing of the registers and register access over APB were chosen for this implementation.
`include "fmp_map.svh"
`default_nettype none
module feature_map_param_decoder
	import fmp_pkg::*;
#(
	parameter int NUM_SLOTS = 24,
	parameter int NUM_REGIONS = 8,
	parameter int ADDR_W = 32
) (
	input  wire logic              i_clock,
	input  wire logic              i_rst,
	input  wire logic              i_psel,
	input  wire logic              i_penable,
	input  wire logic              i_pwrite,
	input  wire logic [11:0]       i_paddr,
	input  wire logic [31:0]       i_pwdata,
	output logic      [31:0]       o_prdata,
	output logic                   o_pready,
	output logic                   o_pslverr,
	input  wire logic              i_cmd_valid,
	input  wire opcode_t           i_cmd_opcode,
	input  wire param_t            i_cmd_param,
	output logic                   o_cmd_ready,
	input  wire logic [ADDR_W-1:0] i_ifm_offset,
	output logic      [ADDR_W-1:0] o_ifm_addr,
	input  wire logic [ADDR_W-1:0] i_ofm_offset,
	output logic      [ADDR_W-1:0] o_ofm_addr,
	output param_t                 o_in_channels,
	output logic                   o_in_signed,
	output var precision_t         o_in_precision,
	output var layout_t            o_in_layout,
	output var in_scale_t          o_in_scale_mode,
	output logic      [1:0]        o_in_round,
	output var upscale_t           o_in_upscale,
	output zero_point_t            o_in_zero_point,
	output param_t                 o_in_tile_a_width,
	output param_t                 o_in_tile_a_height,
	output param_t                 o_in_tile_b_height,
	output buf_limit_t             o_in_buffer_limit,
	output logic      [2:0]        o_in_region,
	output param_t                 o_out_width,
	output param_t                 o_out_height,
	output param_t                 o_out_depth,
	output logic                   o_out_signed,
	output var precision_t         o_out_precision,
	output var layout_t            o_out_layout,
	output logic                   o_out_global_scale,
	output var out_round_t         o_out_round,
	output blk_wh_t                o_blk_width,
	output blk_wh_t                o_blk_height,
	output blk_d_t                 o_blk_depth,
	output zero_point_t            o_out_zero_point,
	output param_t                 o_out_tile_a_width,
	output param_t                 o_out_tile_a_height,
	output param_t                 o_out_tile_b_height,
	output logic      [2:0]        o_out_region,
	output param_t                 o_filter_span_x,
	output param_t                 o_filter_span_y,
	output clip_t                  o_clip_range
);
	localparam int RW = $clog2(NUM_REGIONS);

	function automatic slot_t slot_idx(input opcode_t op);
		case (op)
			`SET_INPUT_CHANNELS_LESS_ONE: slot_idx = 5'h00;
			`SET_INPUT_NUMBER_FORMAT:     slot_idx = 5'h01;
			`SET_INPUT_UPSAMPLING:        slot_idx = 5'h02;
			`SET_INPUT_OFFSET_VALUE:      slot_idx = 5'h03;
			`SET_INPUT_TILE_A_WIDTH:      slot_idx = 5'h04;
			`SET_INPUT_TILE_A_HEIGHT:     slot_idx = 5'h05;
			`SET_INPUT_TILE_B_HEIGHT:     slot_idx = 5'h06;
			`SET_INPUT_BUFFER_LIMIT:      slot_idx = 5'h07;
			`SET_INPUT_BASE_SELECT:       slot_idx = 5'h08;
			`SET_OUTPUT_STRIPE_WIDTH:     slot_idx = 5'h09;
			`SET_OUTPUT_STRIPE_HEIGHT:    slot_idx = 5'h0A;
			`SET_OUTPUT_STRIPE_DEPTH:     slot_idx = 5'h0B;
			`SET_OUTPUT_NUMBER_FORMAT:    slot_idx = 5'h0C;
			`SET_OUTPUT_BLOCK_WIDTH:      slot_idx = 5'h0D;
			`SET_OUTPUT_BLOCK_HEIGHT:     slot_idx = 5'h0E;
			`SET_OUTPUT_BLOCK_DEPTH:      slot_idx = 5'h0F;
			`SET_OUTPUT_OFFSET_VALUE:     slot_idx = 5'h10;
			`SET_OUTPUT_TILE_A_WIDTH:     slot_idx = 5'h11;
			`SET_OUTPUT_TILE_A_HEIGHT:    slot_idx = 5'h12;
			`SET_OUTPUT_TILE_B_HEIGHT:    slot_idx = 5'h13;
			`SET_OUTPUT_BASE_SELECT:      slot_idx = 5'h14;
			`SET_FILTER_SPAN_X:           slot_idx = 5'h15;
			`SET_FILTER_SPAN_Y:           slot_idx = 5'h16;
			`SET_ACTIVATION:              slot_idx = 5'h17;
			default:                      slot_idx = `NO_SLOT;
		endcase
	endfunction

	// Values the stream author must respect; flagged, still stored
	function automatic logic out_of_range(input opcode_t op, input param_t p);
		case (op)
			`SET_INPUT_BUFFER_LIMIT: out_of_range = (p > `IB_END_MAX) || p[0];
			`SET_OUTPUT_BLOCK_WIDTH,
			`SET_OUTPUT_BLOCK_HEIGHT: out_of_range = p > `BLK_WH_MAX;
			`SET_OUTPUT_BLOCK_DEPTH: out_of_range = (p < `BLK_D_MIN) || (p > `BLK_D_MAX);
			default: out_of_range = 1'b0;
		endcase
	endfunction

	function automatic zero_point_t zp_extend(input logic is_signed, input param_t p);
		zp_extend = {is_signed & p[15], p};
	endfunction

	param_t            params_r [NUM_SLOTS];
	logic [ADDR_W-1:0] region_base_r [NUM_REGIONS];
	logic              enable_r;
	logic              rsv_seen_r;
	logic              rsv_seen_nxt;
	logic              range_seen_r;
	logic              range_seen_nxt;
	opcode_t           last_op_r;
	logic [31:0]       rd_data;
	logic              rd_err;

	logic    apb_setup;
	logic    apb_wr;
	logic    ctrl_wr;
	logic    status_wr;
	logic    inject_wr;
	logic    region_hit;
	logic    param_hit;
	logic    clear_pulse;
	logic    cmd_fire;
	opcode_t cmd_op;
	param_t  cmd_par;
	slot_t   wr_slot;
	logic    wr_hit;
	logic    wr_rsv;
	logic    wr_bad;
	slot_t   rd_slot;
	logic [RW-1:0] rd_region;
	param_t  in_fmt;
	param_t  out_fmt;

	assign apb_setup   = i_psel && !i_penable;
	assign apb_wr      = i_psel && i_penable && i_pwrite;
	assign ctrl_wr     = apb_wr && (i_paddr == `REG_CTRL);
	assign status_wr   = apb_wr && (i_paddr == `REG_STATUS);
	assign inject_wr   = apb_wr && (i_paddr == `REG_INJECT);
	assign region_hit  = (i_paddr >= `REG_REGION)
		&& (i_paddr < `REG_REGION + 12'(4 * NUM_REGIONS));
	assign param_hit   = i_paddr >= `REG_PARAM;
	assign rd_region   = i_paddr[2 +: RW];
	assign rd_slot     = slot_idx(`OP_GROUP_BASE | {2'b00, i_paddr[9:2]});
	assign clear_pulse = ctrl_wr && i_pwdata[`CTRL_CLR_BIT];
	assign o_pready    = 1'b1;

	// Stream stalls under any register write so nothing is lost
	assign o_cmd_ready = enable_r && !apb_wr;
	assign cmd_fire    = inject_wr || (i_cmd_valid && o_cmd_ready);
	assign cmd_op      = inject_wr ? i_pwdata[`CMD_OP_LSB +: 10] : i_cmd_opcode;
	assign cmd_par     = inject_wr ? i_pwdata[15:0] : i_cmd_param;
	assign wr_slot     = slot_idx(cmd_op);
	assign wr_hit      = wr_slot != `NO_SLOT;
	assign wr_rsv      = cmd_fire && !wr_hit && (cmd_op >= `SET_INPUT_CHANNELS_LESS_ONE)
		&& (cmd_op <= `SET_FILTER_SPAN_Y);
	assign wr_bad      = cmd_fire && wr_hit && out_of_range(cmd_op, cmd_par);

	always_ff @(posedge i_clock) begin
		if (i_rst || clear_pulse) begin
			for (int i = 0; i < NUM_SLOTS; i++) begin
				params_r[i] <= `PARAM_RESET;
			end
		end else if (cmd_fire && wr_hit) begin
			params_r[wr_slot] <= cmd_par;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			for (int i = 0; i < NUM_REGIONS; i++) begin
				region_base_r[i] <= '0;
			end
		end else if (apb_wr && region_hit) begin
			region_base_r[rd_region] <= ADDR_W'(i_pwdata);
		end
	end

	// Event wins over a same-cycle write-one clear
	assign rsv_seen_nxt = wr_rsv
		|| (rsv_seen_r && !(status_wr && i_pwdata[`STAT_RSV_BIT]));
	assign range_seen_nxt = wr_bad
		|| (range_seen_r && !(status_wr && i_pwdata[`STAT_RNG_BIT]));

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			enable_r     <= `CTRL_RESET;
			rsv_seen_r   <= 1'b0;
			range_seen_r <= 1'b0;
			last_op_r    <= '0;
		end else begin
			rsv_seen_r   <= rsv_seen_nxt;
			range_seen_r <= range_seen_nxt;
			if (ctrl_wr) begin
				enable_r <= i_pwdata[`CTRL_EN_BIT];
			end
			if (cmd_fire) begin
				last_op_r <= cmd_op;
			end
		end
	end

	// Parameter window is read-only; writes there are errors
	always_comb begin
		rd_data = 32'h0000_0000;
		rd_err  = 1'b0;
		if (param_hit) begin
			rd_err = i_pwrite || (rd_slot == `NO_SLOT);
			if (rd_slot != `NO_SLOT) begin
				rd_data = {16'h0000, params_r[rd_slot]};
			end
		end else if (region_hit) begin
			rd_data = 32'(region_base_r[rd_region]);
		end else begin
			case (i_paddr)
				`REG_CTRL: rd_data[`CTRL_EN_BIT] = enable_r;
				`REG_STATUS: begin
					rd_data[`STAT_RSV_BIT] = rsv_seen_r;
					rd_data[`STAT_RNG_BIT] = range_seen_r;
					rd_data[`CMD_OP_LSB +: 10] = last_op_r;
				end
				`REG_INJECT: rd_data = 32'h0000_0000;
				default: rd_err = 1'b1;
			endcase
		end
	end

	// Answer is staged in setup so access completes with no wait
	always_ff @(posedge i_clock) begin
		if (i_rst || !i_psel) begin
			o_prdata  <= 32'h0000_0000;
			o_pslverr <= 1'b0;
		end else if (apb_setup) begin
			o_prdata  <= rd_data;
			o_pslverr <= rd_err;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_ifm_addr <= '0;
			o_ofm_addr <= '0;
		end else begin
			o_ifm_addr <= region_base_r[o_in_region[RW-1:0]] + i_ifm_offset;
			o_ofm_addr <= region_base_r[o_out_region[RW-1:0]] + i_ofm_offset;
		end
	end

	assign in_fmt  = params_r[slot_idx(`SET_INPUT_NUMBER_FORMAT)];
	assign out_fmt = params_r[slot_idx(`SET_OUTPUT_NUMBER_FORMAT)];

	assign o_in_channels      = params_r[slot_idx(`SET_INPUT_CHANNELS_LESS_ONE)];
	assign o_in_signed        = in_fmt[`FMT_SIGN_BIT];
	assign o_in_precision     = precision_t'(in_fmt[`IN_PREC_LSB +: $bits(precision_t)]);
	assign o_in_layout        = layout_t'(in_fmt[`FMT_LAYOUT_LSB +: $bits(layout_t)]);
	assign o_in_scale_mode    = in_scale_t'(in_fmt[`FMT_SCALE_LSB +: $bits(in_scale_t)]);
	assign o_in_round         = in_fmt[`FMT_ROUND_LSB +: 2];
	assign o_in_upscale       = upscale_t'(params_r[slot_idx(`SET_INPUT_UPSAMPLING)]
		[`UPSCALE_LSB +: $bits(upscale_t)]);
	assign o_in_zero_point    = zp_extend(o_in_signed,
		params_r[slot_idx(`SET_INPUT_OFFSET_VALUE)]);
	assign o_in_tile_a_width  = params_r[slot_idx(`SET_INPUT_TILE_A_WIDTH)];
	assign o_in_tile_a_height = params_r[slot_idx(`SET_INPUT_TILE_A_HEIGHT)];
	assign o_in_tile_b_height = params_r[slot_idx(`SET_INPUT_TILE_B_HEIGHT)];
	assign o_in_buffer_limit  = buf_limit_t'(params_r[slot_idx(`SET_INPUT_BUFFER_LIMIT)]);
	assign o_in_region        = 3'(params_r[slot_idx(`SET_INPUT_BASE_SELECT)]);
	assign o_out_width        = params_r[slot_idx(`SET_OUTPUT_STRIPE_WIDTH)];
	assign o_out_height       = params_r[slot_idx(`SET_OUTPUT_STRIPE_HEIGHT)];
	assign o_out_depth        = params_r[slot_idx(`SET_OUTPUT_STRIPE_DEPTH)];
	assign o_out_signed       = out_fmt[`FMT_SIGN_BIT];
	assign o_out_precision    = precision_t'(out_fmt[`OUT_PREC_LSB +: $bits(precision_t)]);
	assign o_out_layout       = layout_t'(out_fmt[`FMT_LAYOUT_LSB +: $bits(layout_t)]);
	assign o_out_global_scale = out_fmt[`FMT_SCALE_LSB];
	assign o_out_round        = out_round_t'(out_fmt[`FMT_ROUND_LSB +: $bits(out_round_t)]);
	assign o_blk_width        = blk_wh_t'(params_r[slot_idx(`SET_OUTPUT_BLOCK_WIDTH)]);
	assign o_blk_height       = blk_wh_t'(params_r[slot_idx(`SET_OUTPUT_BLOCK_HEIGHT)]);
	assign o_blk_depth        = blk_d_t'(params_r[slot_idx(`SET_OUTPUT_BLOCK_DEPTH)]);
	assign o_out_zero_point   = zp_extend(o_out_signed,
		params_r[slot_idx(`SET_OUTPUT_OFFSET_VALUE)]);
	assign o_out_tile_a_width  = params_r[slot_idx(`SET_OUTPUT_TILE_A_WIDTH)];
	assign o_out_tile_a_height = params_r[slot_idx(`SET_OUTPUT_TILE_A_HEIGHT)];
	assign o_out_tile_b_height = params_r[slot_idx(`SET_OUTPUT_TILE_B_HEIGHT)];
	assign o_out_region        = 3'(params_r[slot_idx(`SET_OUTPUT_BASE_SELECT)]);
	assign o_filter_span_x     = params_r[slot_idx(`SET_FILTER_SPAN_X)];
	assign o_filter_span_y     = params_r[slot_idx(`SET_FILTER_SPAN_Y)];
	assign o_clip_range        = params_r[slot_idx(`SET_ACTIVATION)][`CLIP_LSB +: 4];

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);

	sequence load_s(opcode_t op);
		cmd_fire && (cmd_op == op) && !clear_pulse;
	endsequence

	sequence rsv_s;
		wr_rsv && !clear_pulse;
	endsequence

	chk_in_channels_load: assert property (
		load_s(`SET_INPUT_CHANNELS_LESS_ONE) |=> o_in_channels == $past(cmd_par))
		else $error("input channel count not stored");
	chk_in_fmt_fields: assert property (
		load_s(`SET_INPUT_NUMBER_FORMAT) |=> (o_in_signed == $past(cmd_par[0]))
		&& (o_in_precision == precision_t'($past(cmd_par[3:2]))))
		else $error("input sign or precision wrong");
	chk_in_layout_sel: assert property (
		load_s(`SET_INPUT_NUMBER_FORMAT) |=> o_in_layout == layout_t'($past(cmd_par[7:6])))
		else $error("input layout wrong");
	chk_in_scale_sel: assert property (
		load_s(`SET_INPUT_NUMBER_FORMAT)
		|=> o_in_scale_mode == in_scale_t'($past(cmd_par[9:8])))
		else $error("input scale mode wrong");
	chk_in_round_sel: assert property (
		load_s(`SET_INPUT_NUMBER_FORMAT) |=> o_in_round == $past(cmd_par[15:14]))
		else $error("input rounding wrong");
	chk_upscale_sel: assert property (
		load_s(`SET_INPUT_UPSAMPLING) |=> o_in_upscale == upscale_t'($past(cmd_par[1:0])))
		else $error("upsampling mode wrong");
	chk_in_zero_ext: assert property (
		o_in_zero_point[16] == (o_in_signed && o_in_zero_point[15]))
		else $error("input offset extension wrong");
	chk_in_tile_load: assert property (
		load_s(`SET_INPUT_TILE_B_HEIGHT) |=> o_in_tile_b_height == $past(cmd_par))
		else $error("input tile height not stored");
	chk_buf_limit_flag: assert property (
		load_s(`SET_INPUT_BUFFER_LIMIT) ##0 (cmd_par[0] || cmd_par > 16'h0030)
		|=> range_seen_r ##1 range_seen_r || $past(status_wr))
		else $error("bad buffer limit not flagged");
	chk_in_addr_sum: assert property (
		load_s(`SET_INPUT_BASE_SELECT) |=> (o_in_region == $past(cmd_par[2:0]))
		##1 (o_ifm_addr == $past(region_base_r[o_in_region[RW-1:0]] + i_ifm_offset)))
		else $error("input address base wrong");
	chk_out_stripe_load: assert property (
		load_s(`SET_OUTPUT_STRIPE_DEPTH) |=> o_out_depth == $past(cmd_par))
		else $error("output stripe depth not stored");
	chk_out_fmt_fields: assert property (
		load_s(`SET_OUTPUT_NUMBER_FORMAT) |=> (o_out_signed == $past(cmd_par[0]))
		&& (o_out_precision == precision_t'($past(cmd_par[2:1]))))
		else $error("output sign or precision wrong");
	chk_out_layout_sel: assert property (
		load_s(`SET_OUTPUT_NUMBER_FORMAT) |=> o_out_layout == layout_t'($past(cmd_par[7:6])))
		else $error("output layout wrong");
	chk_out_scale_sel: assert property (
		load_s(`SET_OUTPUT_NUMBER_FORMAT) |=> o_out_global_scale == $past(cmd_par[8]))
		else $error("output scaling wrong");
	chk_out_round_sel: assert property (
		load_s(`SET_OUTPUT_NUMBER_FORMAT)
		|=> o_out_round == out_round_t'($past(cmd_par[15:14])))
		else $error("output rounding wrong");
	chk_blk_depth_range: assert property (
		load_s(`SET_OUTPUT_BLOCK_DEPTH) ##0 (cmd_par < 16'h0003)
		|=> range_seen_r && (o_blk_depth == $past(cmd_par[6:0])))
		else $error("block depth range not flagged");
	chk_out_zero_ext: assert property (
		o_out_zero_point[16] == (o_out_signed && o_out_zero_point[15]))
		else $error("output offset extension wrong");
	chk_out_tile_load: assert property (
		load_s(`SET_OUTPUT_TILE_A_WIDTH) |=> o_out_tile_a_width == $past(cmd_par))
		else $error("output tile width not stored");
	chk_out_addr_sum: assert property (
		!$past(i_rst) && (o_out_region == $past(o_out_region))
		|-> o_ofm_addr == $past(region_base_r[o_out_region[RW-1:0]] + i_ofm_offset))
		else $error("output address base wrong");
	chk_clip_load: assert property (
		load_s(`SET_ACTIVATION) |=> o_clip_range == $past(cmd_par[15:12]))
		else $error("clip range not stored");
	chk_rsv_hold: assert property (
		rsv_s |=> rsv_seen_r && $stable(o_in_channels) && $stable(o_filter_span_y)
		&& $stable(o_out_depth))
		else $error("reserved opcode changed state");
	chk_span_load: assert property (
		load_s(`SET_FILTER_SPAN_X)
		|=> (o_filter_span_x == $past(cmd_par)) && $stable(o_filter_span_y))
		else $error("filter span not stored");
endmodule // feature_map_param_decoder
`default_nettype wire

// ===== fmp_cmd_source.sv
`default_nettype none
module fmp_cmd_source
	import fmp_pkg::*;
(
	input  wire logic    i_clock,
	input  wire logic    i_rst,
	input  wire logic    i_go,
	input  wire opcode_t i_op,
	input  wire param_t  i_par,
	input  wire logic    i_ready,
	output logic         o_valid = 1'b0,
	output opcode_t      o_opcode = 10'h000,
	output param_t       o_param = 16'h0000
);
	timeunit 1ns;
	timeprecision 1ps;
	// legal values
	// Caller picks them; here a transfer is held until taken, then lines scrambled
	always @(posedge i_clock) begin
		if (i_rst) begin
			o_valid <= 1'b0;
		end else if (o_valid && i_ready) begin
			o_valid <= 1'b0;
			o_opcode <= ~o_opcode;
			o_param <= ~o_param;
		end else if (i_go && !o_valid) begin
			o_valid <= 1'b1;
			o_opcode <= i_op;
			o_param <= i_par;
		end
	end
endmodule // fmp_cmd_source
`default_nettype wire

// ===== tb_top.sv
`default_nettype none
module tb_top
	import fmp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
	$display("Error at %0t ns: got %h want %h", $time, a, e); end end
	logic        i_clock = 1'b0, i_rst = 1'b1, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
	logic [11:0] i_paddr = 12'h000;
	logic [31:0] i_pwdata = 32'h00000000, i_ifm_offset = 32'h00000123, i_ofm_offset = 32'h00000456;
	logic [31:0] o_prdata, o_ifm_addr, o_ofm_addr, rd;
	logic        o_pready, o_pslverr, o_cmd_ready, o_in_signed, o_out_signed, o_out_global_scale;
	logic        i_cmd_valid, err, go = 1'b0;
	opcode_t     i_cmd_opcode, op_q = 10'h000;
	param_t      i_cmd_param, par_q = 16'h0000, o_in_channels, o_in_tile_a_width;
	param_t      o_in_tile_a_height, o_in_tile_b_height, o_out_width, o_out_height, o_out_depth;
	param_t      o_out_tile_a_width, o_out_tile_a_height, o_out_tile_b_height;
	param_t      o_filter_span_x, o_filter_span_y;
	precision_t  o_in_precision, o_out_precision;
	layout_t     o_in_layout, o_out_layout;
	in_scale_t   o_in_scale_mode;
	upscale_t    o_in_upscale;
	out_round_t  o_out_round;
	logic [1:0]  o_in_round;
	zero_point_t o_in_zero_point, o_out_zero_point;
	buf_limit_t  o_in_buffer_limit;
	logic [2:0]  o_in_region, o_out_region;
	blk_wh_t     o_blk_width, o_blk_height;
	blk_d_t      o_blk_depth;
	clip_t       o_clip_range;
	int          bad_count = 0, num_checks = 0;
	opcode_t     ops [12] = '{10'h104, 10'h10A, 10'h10B, 10'h10C, 10'h111, 10'h112,
		10'h113, 10'h11A, 10'h11B, 10'h11C, 10'h120, 10'h121};
	opcode_t     rsv [7] = '{10'h106, 10'h108, 10'h10E, 10'h110, 10'h119, 10'h11D, 10'h11E};
	clip_t       clips [4] = '{4'h0, 4'h2, 4'h3, 4'h5};
	feature_map_param_decoder u_feature_map_param_decoder (.i_clock, .i_rst, .i_psel,
		.i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
		.i_cmd_valid, .i_cmd_opcode, .i_cmd_param, .o_cmd_ready, .i_ifm_offset, .o_ifm_addr,
		.i_ofm_offset, .o_ofm_addr, .o_in_channels, .o_in_signed, .o_in_precision,
		.o_in_layout, .o_in_scale_mode, .o_in_round, .o_in_upscale, .o_in_zero_point,
		.o_in_tile_a_width, .o_in_tile_a_height, .o_in_tile_b_height, .o_in_buffer_limit,
		.o_in_region, .o_out_width, .o_out_height, .o_out_depth, .o_out_signed,
		.o_out_precision, .o_out_layout, .o_out_global_scale, .o_out_round, .o_blk_width,
		.o_blk_height, .o_blk_depth, .o_out_zero_point, .o_out_tile_a_width,
		.o_out_tile_a_height, .o_out_tile_b_height, .o_out_region, .o_filter_span_x,
		.o_filter_span_y, .o_clip_range);
	fmp_cmd_source u_fmp_cmd_source (.i_clock, .i_rst, .i_go(go), .i_op(op_q), .i_par(par_q),
		.i_ready(o_cmd_ready), .o_valid(i_cmd_valid), .o_opcode(i_cmd_opcode), .o_param(i_cmd_param));
	always #2.5 i_clock = ~i_clock;
	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic timeout();
		bad_count++;
		$display("Error at %0t ns: wait ran out", $time);
		tally_and_finish();
	endtask
	// Entered just after an edge; request held until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		i_psel <= 1'b1; i_pwrite <= w; i_paddr <= a; i_pwdata <= d;
		@(posedge i_clock) i_penable <= 1'b1;
		for (k = 0; k < 8; k++) begin
			@(posedge i_clock);
			if (o_pready === 1'b1) break;
		end
		if (k == 8) timeout();
		rd = o_prdata;
		err = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
		@(posedge i_clock);
	endtask
	// Extra edge at the end so stored values are visible on return
	task automatic cmd(input opcode_t op, input param_t p);
		int k;
		go <= 1'b1; op_q <= op; par_q <= p;
		@(posedge i_clock) go <= 1'b0;
		for (k = 0; k < 8; k++) begin
			@(posedge i_clock);
			if (i_cmd_valid === 1'b1 && o_cmd_ready === 1'b1) break;
		end
		if (k == 8) timeout();
		@(posedge i_clock);
	endtask
	task automatic t_words();
		logic [191:0] all;
		for (int i = 0; i < 12; i++) cmd(ops[i], 16'hFFFF - 16'(i));
		all = {o_in_channels, o_in_tile_a_width, o_in_tile_a_height, o_in_tile_b_height,
			o_out_width, o_out_height, o_out_depth, o_out_tile_a_width, o_out_tile_a_height,
			o_out_tile_b_height, o_filter_span_x, o_filter_span_y};
		for (int i = 0; i < 12; i++) begin
			`CHK(all[16 * (11 - i) +: 16], 16'hFFFF - 16'(i))
			apb(1'b0, 12'h400 + 12'(4 * (ops[i] - 10'h100)), 32'h00000000);
			`CHK(rd[15:0], 16'hFFFF - 16'(i))
		end
		$display("Test stored words done");
	endtask
	task automatic t_formats();
		cmd(10'h105, 16'h8245);
		`CHK({o_in_signed, o_in_precision, o_in_round}, {1'b1, PREC_16BIT, 2'h2})
		`CHK({o_in_layout, o_in_scale_mode}, {CHANNEL_BRICK_LAYOUT, SCALE_32_SECOND})
		cmd(10'h109, 16'h8001);
		`CHK(o_in_zero_point, 17'h18001)
		cmd(10'h105, 16'h0104);
		`CHK({o_in_signed, o_in_scale_mode, o_in_zero_point}, {1'b0, SCALE_32_FIRST, 17'h08001})
		for (int m = 0; m < 3; m++) begin
			cmd(10'h107, 16'(m));
			`CHK(o_in_upscale, upscale_t'(m))
		end
		cmd(10'h114, 16'h4145);
		`CHK({o_out_signed, o_out_precision, o_out_layout}, {1'b1, PREC_32BIT, CHANNEL_BRICK_LAYOUT})
		`CHK({o_out_global_scale, o_out_round}, {1'b1, ROUND_TRUNCATE})
		cmd(10'h114, 16'h8002);
		`CHK({o_out_signed, o_out_precision, o_out_layout}, {1'b0, PREC_16BIT, PIXEL_MAJOR_LAYOUT})
		`CHK({o_out_global_scale, o_out_round}, {1'b0, ROUND_NATURAL})
		cmd(10'h118, 16'h8001);
		`CHK(o_out_zero_point, 17'h08001)
		cmd(10'h114, 16'h0003);
		`CHK(o_out_zero_point, 17'h18001)
		for (int m = 0; m < 4; m++) begin
			cmd(10'h125, {clips[m], 12'h010});
			`CHK(o_clip_range, clips[m])
		end
		$display("Test formats done");
	endtask
	task automatic t_limits();
		cmd(10'h10D, 16'h0030); cmd(10'h115, 16'h001F); cmd(10'h116, 16'h0000); cmd(10'h117, 16'h0003);
		`CHK({o_in_buffer_limit, o_blk_width, o_blk_height, o_blk_depth}, {6'h30, 5'h1F, 5'h00, 7'h03})
		cmd(10'h117, 16'h007F);
		`CHK(o_blk_depth, 7'h7F)
		apb(1'b0, 12'h004, 32'h00000000);
		`CHK(rd[1:0], 2'b00)
		$display("Test limits done");
	endtask
	task automatic t_regions();
		for (int n = 0; n < 8; n++) apb(1'b1, 12'h040 + 12'(4 * n), 32'h00010000 * n + 32'h00000010);
		cmd(10'h10F, 16'h0005); cmd(10'h11F, 16'h0007);
		@(posedge i_clock);
		`CHK({o_in_region, o_ifm_addr}, {3'h5, 32'h00050133})
		`CHK({o_out_region, o_ofm_addr}, {3'h7, 32'h00070466})
		apb(1'b0, 12'h300, 32'h00000000);
		`CHK(err, 1'b1)
		$display("Test regions done");
	endtask
	task automatic t_reserved();
		cmd(10'h104, 16'h1234);
		for (int r = 0; r < 7; r++) cmd(rsv[r], 16'hFFFF);
		`CHK({o_in_channels, o_in_region, o_out_region}, {16'h1234, 3'h5, 3'h7})
		`CHK({o_in_upscale, o_blk_depth}, {UPSCALE_ZEROS, 7'h7F})
		apb(1'b0, 12'h004, 32'h00000000);
		`CHK({rd[25:16], rd[0]}, {10'h11E, 1'b1})
		$display("Test reserved done");
	endtask
	// Software injection is the only way to see the range flag without a bad stream
	task automatic t_ctrl();
		apb(1'b1, 12'h008, 32'h01170002);
		apb(1'b1, 12'h008, 32'h010D0031);
		`CHK({o_blk_depth, o_in_buffer_limit}, {7'h02, 6'h31})
		apb(1'b0, 12'h004, 32'h00000000);
		`CHK(rd[1], 1'b1)
		apb(1'b1, 12'h004, 32'h00000002);
		apb(1'b0, 12'h004, 32'h00000000);
		`CHK(rd[1:0], 2'b01)
		apb(1'b1, 12'h000, 32'h00000000);
		`CHK(o_cmd_ready, 1'b0)
		apb(1'b1, 12'h000, 32'h00000003);
		`CHK({o_cmd_ready, o_blk_depth, o_in_channels}, {1'b1, 7'h00, 16'h0000})
		$display("Test control done");
	endtask
	initial begin
		repeat (20) @(posedge i_clock);
		i_rst <= 1'b0;
		@(posedge i_clock);
		`CHK({o_cmd_ready, o_in_channels, o_out_round}, {1'b1, 16'h0000, ROUND_DOUBLE})
		t_words();
		t_formats();
		t_limits();
		t_regions();
		t_reserved();
		t_ctrl();
		tally_and_finish();
	end
`undef CHK
endmodule // tb_top
`default_nettype wire
